// File: rtl/dmau_pkg.sv
// Constants, types and decode helpers of the data memory access unit.
// Assumes a 125 MHz CPU clock and an 8-bit I/O register port from the core.
package dmau_pkg;

   // ***************************************
   // Types
   // ***************************************
   typedef enum logic [2:0] {
      AM_DIRECT, AM_INDIRECT, AM_DISP, AM_PREDEC, AM_POSTINC
   } addr_mode_t;

   typedef enum logic [2:0] {
      RG_WORK, RG_STD_IO, RG_EXT_IO, RG_INTERNAL_SRAM, RG_EXTERNAL_MEMORY_REGION
   } region_t;

   // ***************************************
   // Data space map
   // ***************************************
   localparam logic [15:0] WORK_END = 16'h001F;
   localparam logic [15:0] STD_IO_END = 16'h005F;
   localparam logic [15:0] EXT_IO_END = 16'h00FF;
   localparam logic [15:0] INTERNAL_SRAM_END = 16'h20FF;
   localparam logic [15:0] PTR_STEP = 16'h0001;

   // ***************************************
   // I/O register offsets and fields
   // ***************************************
   localparam logic [7:0] XMCA_OFS = 8'h74;
   localparam logic [7:0] NVM_CTRL_OFS = 8'h1F;
   localparam logic [7:0] NVM_DATA_OFS = 8'h20;
   localparam logic [7:0] NVM_ADDRL_OFS = 8'h21;
   localparam logic [7:0] NVM_ADDRH_OFS = 8'h22;
   localparam int SRE_BIT = 7;
   localparam int WS_LSB = 0;
   localparam int PM_LSB = 4;
   localparam int MPE_BIT = 2;
   localparam int PE_BIT = 1;
   localparam int RE_BIT = 0;
   localparam logic [1:0] PM_ATOMIC = 2'h0;
   localparam logic [1:0] PM_ERASE = 2'h1;
   localparam logic [1:0] PM_WRITE = 2'h2;
   localparam logic [1:0] PM_RSVD = 2'h3;
   localparam logic [7:0] XMCA_RESET = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam int NVM_AW = 12;

   // ***************************************
   // Timing
   // ***************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam logic [3:0] EXT_EXTRA = 4'h1;
   localparam logic [3:0] PC_EXTRA = 4'h3;
   localparam logic [1:0] MPE_LOAD = 2'h3;
   localparam logic [2:0] RD_HALT_LOAD = 3'h3;
   localparam logic [2:0] WR_HALT_LOAD = 3'h1;
   localparam int NVM_ATOMIC_NS = 3400000;
   localparam int NVM_SPLIT_NS = 1800000;
   localparam int NVM_ATOMIC_CYC = NVM_ATOMIC_NS / CLK_PERIOD_NS;
   localparam int NVM_SPLIT_CYC = NVM_SPLIT_NS / CLK_PERIOD_NS;

   // Region of a data address
   function automatic region_t decode_region(input logic [15:0] a);
      region_t r;
      if (a <= WORK_END) begin
         r = RG_WORK;
      end else if (a <= STD_IO_END) begin
         r = RG_STD_IO;
      end else if (a <= EXT_IO_END) begin
         r = RG_EXT_IO;
      end else if (a <= INTERNAL_SRAM_END) begin
         r = RG_INTERNAL_SRAM;
      end else begin
         r = RG_EXTERNAL_MEMORY_REGION;
      end
      return r;
   endfunction : decode_region

endpackage : dmau_pkg

// File: rtl/dmau_addr_gen.sv
// Effective address and pointer update for the five data addressing modes.
// Purely combinational; the caller registers what it keeps.
`timescale 1ns/10ps
module dmau_addr_gen (
   // Request
   input wire dmau_pkg::addr_mode_t mode_in,
   input wire logic [15:0] direct_in,
   input wire logic [15:0] ptr_in,
   input wire logic [5:0] disp_in,
   // Result
   output logic [15:0] eff_addr_out,
   output logic [15:0] ptr_next_out
);

   // Mode select; direct reaches the whole 64K space
   always_comb begin
      eff_addr_out = direct_in;
      ptr_next_out = ptr_in;
      case (mode_in)
         dmau_pkg::AM_INDIRECT: begin
            eff_addr_out = ptr_in;
         end
         dmau_pkg::AM_DISP: begin
            eff_addr_out = ptr_in + {10'h000, disp_in};
         end
         dmau_pkg::AM_PREDEC: begin
            eff_addr_out = ptr_in - dmau_pkg::PTR_STEP;
            ptr_next_out = ptr_in - dmau_pkg::PTR_STEP;
         end
         dmau_pkg::AM_POSTINC: begin
            eff_addr_out = ptr_in;
            ptr_next_out = ptr_in + dmau_pkg::PTR_STEP;
         end
         default: begin
            eff_addr_out = direct_in;
         end
      endcase
   end

endmodule : dmau_addr_gen

// File: rtl/dmau_nvm_array.sv
// Byte-wide nonvolatile data array with erase, write and atomic programming.
// Read is combinational; a program commits on the clock edge of wr_en_in.
`timescale 1ns/10ps
module dmau_nvm_array #(
   parameter int AW = dmau_pkg::NVM_AW
) (
   // Clock
   input wire logic ref_clk_in,
   // Access
   input wire logic [11:0] addr_in,
   input wire logic wr_en_in,
   input wire logic [1:0] wr_mode_in,
   input wire logic [7:0] wr_data_in,
   output logic [7:0] rdata_out
);

   logic [7:0] mem [2**AW];
   logic [AW-1:0] idx;

   // Upper bits dropped on smaller variants
   assign idx = addr_in[AW-1:0];
   assign rdata_out = mem[idx];

   // Erase sets all ones; write-only can only clear bits
   always_ff @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         case (wr_mode_in)
            dmau_pkg::PM_ATOMIC: mem[idx] <= wr_data_in;
            dmau_pkg::PM_ERASE: mem[idx] <= dmau_pkg::ERASED_BYTE;
            dmau_pkg::PM_WRITE: mem[idx] <= mem[idx] & wr_data_in;
            default: mem[idx] <= mem[idx];
         endcase
      end
   end

endmodule : dmau_nvm_array

// File: rtl/data_memory_access_unit.sv
// Data space access unit: decode, external SRAM cycles, nonvolatile port.
// Assumes the core holds request fields while dm_req_in is high and
// stalls on dm_busy_out and cpu_halt_out.
`timescale 1ns/10ps
module data_memory_access_unit #(
   parameter int unsigned ATOMIC_CYCLES = dmau_pkg::NVM_ATOMIC_CYC,
   parameter int unsigned SPLIT_CYCLES = dmau_pkg::NVM_SPLIT_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // Data access request
   input wire logic dm_req_in,
   input wire logic dm_we_in,
   input wire logic dm_pc_frame_in,
   input wire dmau_pkg::addr_mode_t dm_mode_in,
   input wire logic [15:0] dm_direct_in,
   input wire logic [15:0] dm_ptr_in,
   input wire logic [5:0] dm_disp_in,
   input wire logic [7:0] dm_wdata_in,
   // Data access answer
   output logic dm_busy_out,
   output logic dm_done_out,
   output logic [7:0] dm_rdata_out,
   output dmau_pkg::region_t dm_region_out,
   output logic [15:0] dm_ptr_next_out,
   // External SRAM pins
   output logic [15:0] ext_addr_out,
   input wire logic [7:0] ext_data_in,
   output logic [7:0] ext_data_out,
   output logic ext_data_oe_out,
   output logic ext_rd_n_out,
   output logic ext_wr_n_out,
   // I/O register port
   input wire logic [7:0] io_addr_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_wdata_in,
   output logic [7:0] io_rdata_out,
   // Core halt and status
   output logic cpu_halt_out,
   output logic nvm_busy_out
);

   // *********************************************
   // Declarations
   // *********************************************
   logic [15:0] eff_addr;
   logic [15:0] ptr_next;
   dmau_pkg::region_t region;
   logic take;
   logic ext_go;
   logic [3:0] cnt;
   logic ext_cycle;
   logic [7:0] ext_memory_control_a;
   logic ext_sram_enable;
   logic [1:0] wait_states;
   logic [11:0] nvm_address;
   logic [7:0] nvm_data;
   logic [7:0] nvm_wbyte;
   logic [1:0] nvm_program_mode;
   logic nvm_master_write_enable;
   logic [1:0] mpe_cnt;
   logic nvm_write_strobe;
   logic [19:0] prog_cnt;
   logic [2:0] halt_cnt;
   logic [7:0] arr_rdata;
   logic ctrl_wr;
   logic wr_start;
   logic rd_start;
   logic commit;

   // Extra cycles of an external access
   function automatic logic [3:0] ext_extra(input logic [1:0] ws, input logic pc);
      logic [3:0] w;
      w = {2'h0, ws};
      if (pc) begin
         return dmau_pkg::PC_EXTRA + (w << 1);
      end
      return dmau_pkg::EXT_EXTRA + w;
   endfunction : ext_extra

   // *********************************************
   // Address generation and decode
   // *********************************************
   dmau_addr_gen u_addr_gen (
      .mode_in(dm_mode_in),
      .direct_in(dm_direct_in),
      .ptr_in(dm_ptr_in),
      .disp_in(dm_disp_in),
      .eff_addr_out(eff_addr),
      .ptr_next_out(ptr_next)
   );

   // Region, request acceptance, external qualification
   assign region = dmau_pkg::decode_region(eff_addr);
   assign take = dm_req_in && !dm_busy_out;
   assign ext_go = (region == dmau_pkg::RG_EXTERNAL_MEMORY_REGION) && ext_sram_enable;
   assign ext_sram_enable = ext_memory_control_a[dmau_pkg::SRE_BIT];
   assign wait_states = ext_memory_control_a[dmau_pkg::WS_LSB +: 2];

   // *********************************************
   // Data access sequencer
   // *********************************************
   // Counter loaded with the extra cycles; internal access ends at cycle 2
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dm_busy_out <= 1'b0;
         dm_done_out <= 1'b0;
         cnt <= 4'h0;
         ext_cycle <= 1'b0;
         dm_region_out <= dmau_pkg::RG_WORK;
         dm_ptr_next_out <= 16'h0000;
      end else if (take) begin
         dm_busy_out <= 1'b1;
         dm_done_out <= 1'b0;
         cnt <= ext_go ? ext_extra(wait_states, dm_pc_frame_in) : 4'h0;
         ext_cycle <= ext_go;
         dm_region_out <= region;
         dm_ptr_next_out <= ptr_next;
      end else if (dm_busy_out) begin
         if (cnt == 4'h0) begin
            dm_busy_out <= 1'b0;
            dm_done_out <= 1'b1;
            ext_cycle <= 1'b0;
         end else begin
            cnt <= cnt - 4'h1;
         end
      end else begin
         dm_done_out <= 1'b0;
      end
   end

   // External strobes, address and data bus
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ext_addr_out <= 16'h0000;
         ext_data_out <= 8'h00;
         ext_data_oe_out <= 1'b0;
         ext_rd_n_out <= 1'b1;
         ext_wr_n_out <= 1'b1;
      end else if (take && ext_go) begin
         ext_addr_out <= eff_addr;
         ext_data_out <= dm_wdata_in;
         ext_data_oe_out <= dm_we_in;
         ext_rd_n_out <= dm_we_in;
         ext_wr_n_out <= !dm_we_in;
      end else if (!ext_cycle || cnt == 4'h0) begin
         ext_data_oe_out <= 1'b0;
         ext_rd_n_out <= 1'b1;
         ext_wr_n_out <= 1'b1;
      end
   end

   // Read data captured as the external cycle ends
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dm_rdata_out <= 8'h00;
      end else if (take) begin
         dm_rdata_out <= 8'h00;
      end else if (ext_cycle && cnt == 4'h0 && !ext_rd_n_out) begin
         dm_rdata_out <= ext_data_in;
      end
   end

   // *********************************************
   // Nonvolatile port controls
   // *********************************************
   // A write starts only while the unlock window is open
   assign ctrl_wr = io_wr_in && (io_addr_in == dmau_pkg::NVM_CTRL_OFS);
   assign wr_start = ctrl_wr && io_wdata_in[dmau_pkg::PE_BIT] && nvm_master_write_enable
                     && !nvm_write_strobe && (nvm_program_mode != dmau_pkg::PM_RSVD);
   assign rd_start = ctrl_wr && io_wdata_in[dmau_pkg::RE_BIT] && !nvm_write_strobe;
   assign commit = nvm_write_strobe && (prog_cnt == 20'h00000);
   assign nvm_busy_out = nvm_write_strobe;

   dmau_nvm_array #(
      .AW(dmau_pkg::NVM_AW)
   ) u_nvm_array (
      .ref_clk_in(ref_clk_in),
      .addr_in(nvm_address),
      .wr_en_in(commit),
      .wr_mode_in(nvm_program_mode),
      .wr_data_in(nvm_wbyte),
      .rdata_out(arr_rdata)
   );

   // Master enable times out so a stray strobe write cannot program
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         nvm_master_write_enable <= 1'b0;
         mpe_cnt <= 2'h0;
      end else if (ctrl_wr && io_wdata_in[dmau_pkg::MPE_BIT]) begin
         nvm_master_write_enable <= 1'b1;
         mpe_cnt <= dmau_pkg::MPE_LOAD;
      end else if (nvm_master_write_enable) begin
         if (mpe_cnt == 2'h0) begin
            nvm_master_write_enable <= 1'b0;
         end else begin
            mpe_cnt <= mpe_cnt - 2'h1;
         end
      end
   end

   // Self-timed programming; the strobe clears when time elapses
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         nvm_write_strobe <= 1'b0;
         prog_cnt <= 20'h00000;
         nvm_wbyte <= 8'h00;
      end else if (wr_start) begin
         nvm_write_strobe <= 1'b1;
         nvm_wbyte <= nvm_data;
         if (nvm_program_mode == dmau_pkg::PM_ATOMIC) begin
            prog_cnt <= 20'(ATOMIC_CYCLES - 1);
         end else begin
            prog_cnt <= 20'(SPLIT_CYCLES - 1);
         end
      end else if (commit) begin
         nvm_write_strobe <= 1'b0;
      end else if (nvm_write_strobe) begin
         prog_cnt <= prog_cnt - 20'h00001;
      end
   end

   // Mode bits frozen while programming
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         nvm_program_mode <= dmau_pkg::PM_ATOMIC;
      end else if (ctrl_wr && !nvm_write_strobe) begin
         nvm_program_mode <= io_wdata_in[dmau_pkg::PM_LSB +: 2];
      end
   end

   // Address register; no reset value is promised to software
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         nvm_address <= 12'h000;
      end else if (io_wr_in && !nvm_write_strobe) begin
         if (io_addr_in == dmau_pkg::NVM_ADDRL_OFS) begin
            nvm_address[7:0] <= io_wdata_in;
         end else if (io_addr_in == dmau_pkg::NVM_ADDRH_OFS) begin
            nvm_address[11:8] <= io_wdata_in[3:0];
         end
      end
   end

   // Data register: software byte or array byte on a read strobe
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         nvm_data <= 8'h00;
      end else if (rd_start) begin
         nvm_data <= arr_rdata;
      end else if (io_wr_in && io_addr_in == dmau_pkg::NVM_DATA_OFS) begin
         nvm_data <= io_wdata_in;
      end
   end

   // Core halt after a strobe: four cycles on read, two on write
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cpu_halt_out <= 1'b0;
         halt_cnt <= 3'h0;
      end else if (rd_start) begin
         cpu_halt_out <= 1'b1;
         halt_cnt <= dmau_pkg::RD_HALT_LOAD;
      end else if (wr_start) begin
         cpu_halt_out <= 1'b1;
         halt_cnt <= dmau_pkg::WR_HALT_LOAD;
      end else if (cpu_halt_out) begin
         if (halt_cnt == 3'h0) begin
            cpu_halt_out <= 1'b0;
         end else begin
            halt_cnt <= halt_cnt - 3'h1;
         end
      end
   end

   // *********************************************
   // External memory control and readback
   // *********************************************
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ext_memory_control_a <= dmau_pkg::XMCA_RESET;
      end else if (io_wr_in && io_addr_in == dmau_pkg::XMCA_OFS) begin
         ext_memory_control_a <= io_wdata_in;
      end
   end

   // Registered readback; unmapped offsets read zero
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         io_rdata_out <= 8'h00;
      end else if (io_rd_in) begin
         if (io_addr_in == dmau_pkg::XMCA_OFS) begin
            io_rdata_out <= ext_memory_control_a;
         end else if (io_addr_in == dmau_pkg::NVM_CTRL_OFS) begin
            io_rdata_out <= {2'h0, nvm_program_mode, 1'b0, nvm_master_write_enable,
                             nvm_write_strobe, 1'b0};
         end else if (io_addr_in == dmau_pkg::NVM_DATA_OFS) begin
            io_rdata_out <= nvm_data;
         end else if (io_addr_in == dmau_pkg::NVM_ADDRL_OFS) begin
            io_rdata_out <= nvm_address[7:0];
         end else if (io_addr_in == dmau_pkg::NVM_ADDRH_OFS) begin
            io_rdata_out <= {4'h0, nvm_address[11:8]};
         end else begin
            io_rdata_out <= 8'h00;
         end
      end
   end

   // *********************************************
   // Assertions
   // *********************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   property p_int_strobes;
      take && !ext_go |=> (ext_rd_n_out && ext_wr_n_out)[*2];
   endproperty
   a_int_strobes: assert property (p_int_strobes) else $error("strobe on internal");

   property p_sre_gate;
      take && !ext_sram_enable |=> (ext_rd_n_out && ext_wr_n_out && !ext_data_oe_out)[*2];
   endproperty
   a_sre_gate: assert property (p_sre_gate) else $error("strobe without enable");

   property p_int_two;
      take && !ext_go |=> !dm_done_out ##1 dm_done_out;
   endproperty
   a_int_two: assert property (p_int_two) else $error("internal not 2 cycles");

   property p_ext_zero_ws;
      take && ext_go && wait_states == 2'h0 && !dm_pc_frame_in |-> ##2 !dm_done_out ##1 dm_done_out;
   endproperty
   a_ext_zero_ws: assert property (p_ext_zero_ws) else $error("ext not 3 cycles");

   property p_ext_pc_ws3;
      take && ext_go && wait_states == 2'h3 && dm_pc_frame_in |-> ##11 dm_done_out;
   endproperty
   a_ext_pc_ws3: assert property (p_ext_pc_ws3) else $error("pc frame not +9");

   property p_mpe_window;
      $rose(nvm_master_write_enable) && !ctrl_wr |-> nvm_master_write_enable[*4];
   endproperty
   a_mpe_window: assert property (p_mpe_window) else $error("mpe window wrong");

   property p_rd_halt;
      rd_start |=> cpu_halt_out[*4] ##1 !cpu_halt_out;
   endproperty
   a_rd_halt: assert property (p_rd_halt) else $error("read halt not 4");

   property p_wr_halt;
      wr_start |=> cpu_halt_out[*2] ##1 !cpu_halt_out;
   endproperty
   a_wr_halt: assert property (p_wr_halt) else $error("write halt not 2");

   property p_addr_frozen;
      nvm_write_strobe |=> $stable(nvm_address);
   endproperty
   a_addr_frozen: assert property (p_addr_frozen) else $error("address moved");

   property p_hi_zero;
      io_rd_in && io_addr_in == dmau_pkg::NVM_ADDRH_OFS |=> io_rdata_out[7:4] == 4'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("reserved bits set");

endmodule : data_memory_access_unit

// File: test/ext_sram_model.sv
// External SRAM chip model hanging on the strobe pins of the access unit.
// Assumes active-low strobes and a registered address from the unit.
`timescale 1ns/10ps
module ext_sram_model (
   // Clock
   input wire logic ref_clk_in,
   // Memory pins
   input wire logic [15:0] ext_addr_in,
   input wire logic [7:0] ext_data_in,
   input wire logic ext_rd_n_in,
   input wire logic ext_wr_n_in,
   output logic [7:0] ext_data_out
);
   logic [7:0] mem [int];
   logic [7:0] last = 8'h00;
   // Store on every edge that sees the write strobe low
   always @(posedge ref_clk_in) begin
      if (!ext_wr_n_in) begin
         mem[ext_addr_in] = ext_data_in;
      end
      if (!ext_rd_n_in) begin
         last <= ext_data_out;
      end
   end
   // Released bus shows the inverse byte, so a late sample cannot pass
   always @* begin
      if (!ext_rd_n_in) begin
         ext_data_out = mem.exists(ext_addr_in) ? mem[ext_addr_in] : 8'hA5;
      end else begin
         ext_data_out = ~last;
      end
   end
endmodule : ext_sram_model

// File: test/data_memory_access_unit_tb.sv
// Self-checking bench of the data memory access unit.
// Assumes the external SRAM model and shortened programming counts.
`timescale 1ns/10ps
module data_memory_access_unit_tb;
   localparam int AT_CYC = 20;
   localparam int SP_CYC = 16;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic dm_req_in = 1'b0, dm_we_in = 1'b0, dm_pc_frame_in = 1'b0;
   dmau_pkg::addr_mode_t dm_mode_in = dmau_pkg::AM_DIRECT;
   logic [15:0] dm_direct_in = 16'h0000, dm_ptr_in = 16'h0000;
   logic [5:0] dm_disp_in = 6'h00;
   logic [7:0] dm_wdata_in = 8'h00, io_addr_in = 8'h00, io_wdata_in = 8'h00;
   logic io_wr_in = 1'b0, io_rd_in = 1'b0;
   logic dm_busy_out, dm_done_out, ext_data_oe_out, ext_rd_n_out, ext_wr_n_out;
   logic cpu_halt_out, nvm_busy_out;
   logic [7:0] dm_rdata_out, ext_data_in, ext_data_out, io_rdata_out;
   logic [15:0] dm_ptr_next_out, ext_addr_out;
   dmau_pkg::region_t dm_region_out;
   logic [7:0] mir [int];
   int n_fail = 0;
   int samples_checked = 0;
   // Free-running 125 MHz clock
   always #4 ref_clk_in = ~ref_clk_in;
   data_memory_access_unit #(.ATOMIC_CYCLES(AT_CYC), .SPLIT_CYCLES(SP_CYC)) i_dut (
      .ref_clk_in, .resetn_in, .dm_req_in, .dm_we_in, .dm_pc_frame_in, .dm_mode_in,
      .dm_direct_in, .dm_ptr_in, .dm_disp_in, .dm_wdata_in, .dm_busy_out, .dm_done_out,
      .dm_rdata_out, .dm_region_out, .dm_ptr_next_out, .ext_addr_out, .ext_data_in,
      .ext_data_out, .ext_data_oe_out, .ext_rd_n_out, .ext_wr_n_out, .io_addr_in,
      .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out, .cpu_halt_out, .nvm_busy_out);
   ext_sram_model i_mem (.ref_clk_in, .ext_addr_in(ext_addr_out), .ext_data_in(ext_data_out),
      .ext_rd_n_in(ext_rd_n_out), .ext_wr_n_in(ext_wr_n_out), .ext_data_out(ext_data_in));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Inputs move 1 ns after the edge, never on it
   task automatic tick;
      @(posedge ref_clk_in);
      #1;
   endtask : tick
   task automatic io_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
      tick();
      io_addr_in = a;
      io_wdata_in = d;
      io_wr_in = wr;
      io_rd_in = !wr;
      tick();
      io_wr_in = 1'b0;
      io_rd_in = 1'b0;
   endtask : io_op
   task automatic halt_cnt(output int n);
      n = 0;
      repeat (8) begin
         if (cpu_halt_out === 1'b1) n++;
         tick();
      end
   endtask : halt_cnt
   // One program pass, then read back through the data register
   task automatic nvm_prog(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d,
                           input logic [7:0] exp);
      int n;
      int k;
      io_op(1, dmau_pkg::NVM_ADDRL_OFS, a[7:0]);
      io_op(1, dmau_pkg::NVM_ADDRH_OFS, {4'hF, a[11:8]});
      io_op(0, dmau_pkg::NVM_ADDRH_OFS, 8'h00);
      chk("addr_high", {12'h000, a[11:8]}, {8'h00, io_rdata_out});
      io_op(1, dmau_pkg::NVM_DATA_OFS, d);
      io_op(1, dmau_pkg::NVM_CTRL_OFS, {2'b00, m, 4'h4});
      io_op(1, dmau_pkg::NVM_CTRL_OFS, {2'b00, m, 4'h2});
      chk("prog_busy", 16'(m != 2'h3), {15'h0, nvm_busy_out});
      if (m != 2'h3) begin
         halt_cnt(n);
         chk("write_halt", 16'h0002, 16'(n));
         io_op(1, dmau_pkg::NVM_ADDRL_OFS, ~a[7:0]);
         k = 11;
         while (nvm_busy_out !== 1'b0 && k < 200) begin
            tick();
            k++;
         end
         chk("prog_time", 16'((m == 0 ? AT_CYC : SP_CYC) + 1), 16'(k));
         io_op(0, dmau_pkg::NVM_ADDRL_OFS, 8'h00);
         chk("addr_low", {8'h00, a[7:0]}, {8'h00, io_rdata_out});
      end
      io_op(1, dmau_pkg::NVM_CTRL_OFS, 8'h01);
      halt_cnt(n);
      chk("read_halt", 16'h0004, 16'(n));
      io_op(0, dmau_pkg::NVM_DATA_OFS, 8'h00);
      chk("nvm_byte", {8'h00, exp}, {8'h00, io_rdata_out});
   endtask : nvm_prog
   // One data access with the expected decode and cycle cost
   task automatic acc(input logic we, fr, input int m, input logic [15:0] dir, p,
                      input logic [5:0] ds, input logic [7:0] wd, input logic en,
                      input int ws);
      logic [15:0] eff, nxt, ea;
      int rg, e, k, s, o, bz;
      logic ext;
      case (m)
         0: eff = dir;
         2: eff = p + 16'(ds);
         3: eff = p - 16'h0001;
         default: eff = p;
      endcase
      nxt = m == 3 ? p - 16'h0001 : m == 4 ? p + 16'h0001 : p;
      rg = eff <= 16'h001F ? 0 : eff <= 16'h005F ? 1 : eff <= 16'h00FF ? 2 :
           eff <= 16'h20FF ? 3 : 4;
      ext = rg == 4 && en;
      e = !ext ? 0 : fr ? 3 + 2 * ws : 1 + ws;
      tick();
      {dm_we_in, dm_pc_frame_in, dm_direct_in, dm_ptr_in} = {we, fr, dir, p};
      {dm_disp_in, dm_wdata_in, dm_req_in} = {ds, wd, 1'b1};
      dm_mode_in = dmau_pkg::addr_mode_t'(m);
      tick();
      dm_req_in = 1'b0;
      k = 1;
      s = 0;
      o = 0;
      bz = 0;
      ea = 16'h0000;
      while (dm_done_out !== 1'b1 && k < 40) begin
         if (s == 0) ea = ext_addr_out;
         if (ext_rd_n_out !== 1'b1 || ext_wr_n_out !== 1'b1) s++;
         if (ext_data_oe_out === 1'b1) o++;
         if (dm_busy_out === 1'b1) bz++;
         tick();
         k++;
      end
      chk("latency", 16'(2 + e), 16'(k));
      chk("region", 16'(rg), {13'h0, dm_region_out});
      chk("strobe_cycles", 16'(ext ? 1 + e : 0), 16'(s));
      chk("oe_cycles", 16'(ext && we ? 1 + e : 0), 16'(o));
      chk("busy_cycles", 16'(1 + e), 16'(bz));
      chk("ptr_next", nxt, dm_ptr_next_out);
      if (ext) chk("ext_addr", eff, ea);
      if (ext && we) mir[eff] = wd;
      if (!we) chk("load_byte", ext ? (mir.exists(eff) ? mir[eff] : 8'hA5) : 16'h0000,
                   {8'h00, dm_rdata_out});
   endtask : acc
   task automatic close_out;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   // Watchdog well beyond the expected run length
   initial begin
      #(8 * 40000);
      n_fail++;
      close_out();
   end
   initial begin
      logic [15:0] b;
      logic en;
      int ws;
      void'($urandom(61));
      repeat (12) @(posedge ref_clk_in);
      #1;
      resetn_in = 1'b1;
      io_op(1, dmau_pkg::NVM_CTRL_OFS, 8'h02);
      chk("no_mpe_busy", 16'h0000, {15'h0, nvm_busy_out});
      nvm_prog(2'h0, 12'hA5C, 8'h5A, 8'h5A);
      nvm_prog(2'h2, 12'hA5C, 8'h0F, 8'h0A);
      nvm_prog(2'h1, 12'hA5C, 8'h00, 8'hFF);
      nvm_prog(2'h3, 12'hA5C, 8'h00, 8'hFF);
      // Mid-run reset: strobes idle high, no access pending
      resetn_in = 1'b0;
      tick();
      chk("reset_state", 16'h0006, {13'h0, ext_rd_n_out, ext_wr_n_out, dm_busy_out});
      resetn_in = 1'b1;
      for (int i = 0; i < 60; i++) begin
         en = $urandom_range(0, 3) != 0;
         ws = $urandom_range(0, 3);
         io_op(1, dmau_pkg::XMCA_OFS, {en, 5'h00, 2'(ws)});
         io_op(0, dmau_pkg::XMCA_OFS, 8'h00);
         chk("ext_ctrl", {8'h00, en, 5'h00, 2'(ws)}, {8'h00, io_rdata_out});
         b = i[0] ? 16'($urandom) : 16'($urandom_range(0, 16'h2140));
         {dm_disp_in, dm_wdata_in} = 14'($urandom);
         acc(1, i[1], i % 5, b, b, dm_disp_in, dm_wdata_in, en, ws);
         acc(0, i[1], i % 5, b, b, dm_disp_in, 8'h00, en, ws);
      end
      close_out();
   end
endmodule : data_memory_access_unit_tb
